// ---- rtl/idle_gate_consts.vh ----
// idle mode clock gating constants: register offsets, field positions, reset values
// assumes inclusion by the idle gating modules only
`ifndef IDLE_GATE_CONSTS_VH
`define IDLE_GATE_CONSTS_VH

// -----------------------------------------------------------------
// register byte addresses
// -----------------------------------------------------------------
`define OFS_POWER_SAVE 4'h0
`define OFS_CLOCK_SEL 4'h4
`define OFS_STATUS 4'h8
`define OFS_GATE 4'hC

// -----------------------------------------------------------------
// power save control fields
// -----------------------------------------------------------------
`define BIT_IDLE 1
`define BIT_EXPANSION 4

// -----------------------------------------------------------------
// clock select fields
// -----------------------------------------------------------------
`define BIT_T0_WATCH 0
`define BIT_WATCH_SUB 1
`define BIT_T4_SUB 2
`define BIT_T5_SUB 3
`define BIT_T6_T0OUT 4
`define BIT_T7_T0OUT 5
`define BIT_CSI_EXT_LO 8
`define BIT_CSI_EXT_HI 12
`define BIT_UART_EXT_LO 13
`define BIT_UART_EXT_HI 14
`define BIT_RTO_T4 15
`define BIT_RTO_T5 16
`define BIT_IRQ6_SUB 17

// -----------------------------------------------------------------
// gate vector bit positions
// -----------------------------------------------------------------
`define G_T0 0
`define G_T4 1
`define G_T5 2
`define G_T6 3
`define G_T7 4
`define G_CSI_LO 5
`define G_UART_TX_LO 10
`define G_RTO 12
`define G_IRQ6 13
`define G_WATCH 14
`define G_OTHERS 15
`define G_WIDTH 16

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define RST_POWER_SAVE 32'h00000000
`define RST_CLOCK_SEL 32'h00000000

`endif

// ---- rtl/idle_unit_select.v ----
// per-unit idle run decision from the clock selections
// assumes the selection word is held steady by the register file
`include "idle_gate_consts.vh"

module idle_unit_select #(
   parameter CSI_CH = 5,
   parameter UART_CH = 2
) (
   // configuration
   input wire sub_present,
   input wire [31:0] sel,
   // per-unit keep-running flags while idle
   output wire [`G_WIDTH-1:0] run_idle
);

   wire t0_run;
   wire t4_run;
   wire t5_run;

   // -----------------------------------------------------------------
   // timers
   // -----------------------------------------------------------------
   assign t0_run = sub_present & sel[`BIT_T0_WATCH] & sel[`BIT_WATCH_SUB];
   assign t4_run = sub_present & sel[`BIT_T4_SUB];
   assign t5_run = sub_present & sel[`BIT_T5_SUB];
   assign run_idle[`G_T0] = t0_run;
   assign run_idle[`G_T4] = t4_run;
   assign run_idle[`G_T5] = t5_run;
   // only chained timers follow timer 0 while it still counts
   assign run_idle[`G_T6] = sel[`BIT_T6_T0OUT] & t0_run;
   assign run_idle[`G_T7] = sel[`BIT_T7_T0OUT] & t0_run;

   // -----------------------------------------------------------------
   // serial channels, one flag per channel
   // -----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < CSI_CH + UART_CH; i = i + 1) begin : g_ser
         // uart flags gate the transmitter only, receivers always stop
         assign run_idle[`G_CSI_LO + i] = sel[`BIT_CSI_EXT_LO + i];
      end
   endgenerate

   // -----------------------------------------------------------------
   // real-time output, irq 6, watch timer, the rest
   // -----------------------------------------------------------------
   assign run_idle[`G_RTO] = sub_present &
      ((sel[`BIT_RTO_T4] & t4_run) | (sel[`BIT_RTO_T5] & t5_run));
   assign run_idle[`G_IRQ6] = sub_present & sel[`BIT_IRQ6_SUB];
   assign run_idle[`G_WATCH] = 1'b1;
   assign run_idle[`G_OTHERS] = 1'b0;

endmodule // idle_unit_select

// ---- rtl/idle_clock_gating.v ----
// idle mode clock gating controller with an avalon-mm register slave
// assumes one clock, enable outputs feed glitch-free clock gate cells downstream
`include "idle_gate_consts.vh"

module idle_clock_gating #(
   parameter CSI_CH = 5,
   parameter UART_CH = 2
) (
   // clock and reset
   input wire SYS_CLK,
   input wire RST_B,
   // avalon-mm slave
   input wire [3:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [3:0] AVS_BYTEENABLE,
   output reg [31:0] AVS_READDATA,
   output wire AVS_WAITREQUEST,
   // system conditions
   input wire SUBCLOCK_PRESENT,
   input wire NMI_REQ,
   input wire IRQ_PENDING_UNMASKED,
   input wire BUS_HOLD_REQUEST,
   input wire BUS_HOLD_GRANT_OK,
   // gating outputs
   output reg IDLE_ACTIVE,
   output reg CPU_CLK_EN,
   output reg ROM_CORR_CLK_EN,
   output reg [`G_WIDTH-1:0] PERIPH_CLK_EN,
   output reg [UART_CH-1:0] UART_RX_CLK_EN,
   output reg PORT_HOLD,
   output reg EXT_BUS_CLK_EN,
   output reg EXT_PINS_FLOAT,
   output reg IRQ_LOW_EN,
   output reg BUS_HOLD_ACKNOWLEDGE
);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   reg [31:0] power_save_control_reg;
   reg [31:0] clock_sel_reg;
   reg ack_reg;
   reg idle_reg;
   reg idle_next;
   wire [`G_WIDTH-1:0] run_idle;
   wire wake;
   wire req;
   wire [31:0] wr_mask;
   wire [31:0] status_word;

   // -----------------------------------------------------------------
   // unit decisions
   // -----------------------------------------------------------------
   idle_unit_select #(
      .CSI_CH(CSI_CH),
      .UART_CH(UART_CH)
   ) u_sel (
      .sub_present(SUBCLOCK_PRESENT),
      .sel(clock_sel_reg),
      .run_idle(run_idle)
   );

   // -----------------------------------------------------------------
   // bus handshake: one wait cycle, answer on the second edge
   // -----------------------------------------------------------------
   assign req = AVS_READ | AVS_WRITE;
   assign AVS_WAITREQUEST = req & ~ack_reg;
   assign wr_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
      {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
   assign status_word = {15'h0000, idle_reg, run_idle};

   // ack toggles once per request so back-to-back requests each wait
   always @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req & ~ack_reg;
      end
   end

   // register writes and read data
   always @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         power_save_control_reg <= `RST_POWER_SAVE;
         clock_sel_reg <= `RST_CLOCK_SEL;
         AVS_READDATA <= 32'h00000000;
      end else begin
         if (AVS_WRITE && !ack_reg) begin
            case (AVS_ADDRESS)
               `OFS_POWER_SAVE: begin
                  power_save_control_reg <= (power_save_control_reg & ~wr_mask) |
                     (AVS_WRITEDATA & wr_mask);
               end
               `OFS_CLOCK_SEL: begin
                  clock_sel_reg <= (clock_sel_reg & ~wr_mask) | (AVS_WRITEDATA & wr_mask);
               end
               default: begin
               end
            endcase
         end
         // leaving idle clears the request bit so software sees it done
         if (idle_reg && wake) begin
            power_save_control_reg[`BIT_IDLE] <= 1'b0;
         end
         if (AVS_READ && !ack_reg) begin
            case (AVS_ADDRESS)
               `OFS_POWER_SAVE: AVS_READDATA <= power_save_control_reg;
               `OFS_CLOCK_SEL: AVS_READDATA <= clock_sel_reg;
               `OFS_STATUS: AVS_READDATA <= status_word;
               `OFS_GATE: AVS_READDATA <= {16'h0000, PERIPH_CLK_EN};
               default: AVS_READDATA <= 32'h00000000;
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // idle state
   // -----------------------------------------------------------------
   assign wake = NMI_REQ | IRQ_PENDING_UNMASKED;

   // wake wins over entry so a pending interrupt never strands the cpu
   always @* begin
      idle_next = idle_reg;
      if (idle_reg && wake) begin
         idle_next = 1'b0;
      end else if (!idle_reg && power_save_control_reg[`BIT_IDLE] && !wake) begin
         idle_next = 1'b1;
      end
   end

   always @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         idle_reg <= 1'b0;
      end else begin
         idle_reg <= idle_next;
      end
   end

   // -----------------------------------------------------------------
   // registered gate outputs, no oscillator wait on release
   // -----------------------------------------------------------------
   always @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         IDLE_ACTIVE <= 1'b0;
         CPU_CLK_EN <= 1'b1;
         ROM_CORR_CLK_EN <= 1'b1;
         PERIPH_CLK_EN <= {`G_WIDTH{1'b1}};
         UART_RX_CLK_EN <= {UART_CH{1'b1}};
         PORT_HOLD <= 1'b0;
         EXT_BUS_CLK_EN <= 1'b1;
         EXT_PINS_FLOAT <= 1'b0;
         IRQ_LOW_EN <= 1'b1;
         BUS_HOLD_ACKNOWLEDGE <= 1'b0;
      end else begin
         IDLE_ACTIVE <= idle_next;
         CPU_CLK_EN <= ~idle_next;
         ROM_CORR_CLK_EN <= ~idle_next;
         PERIPH_CLK_EN <= idle_next ? run_idle : {`G_WIDTH{1'b1}};
         UART_RX_CLK_EN <= {UART_CH{~idle_next}};
         PORT_HOLD <= idle_next;
         EXT_BUS_CLK_EN <= ~idle_next;
         EXT_PINS_FLOAT <= idle_next & power_save_control_reg[`BIT_EXPANSION];
         IRQ_LOW_EN <= 1'b1;
         // hold granted only outside idle
         BUS_HOLD_ACKNOWLEDGE <= BUS_HOLD_REQUEST & BUS_HOLD_GRANT_OK & ~idle_next;
      end
   end

endmodule // idle_clock_gating

// ---- bench/idle_gate_monitor.sv ----
// checker for the idle gating controller, bound to its top module
// assumes one clock domain and an active low asynchronous reset
module idle_gate_monitor #(parameter UART_CH = 2) (
   // clock, reset and bus
   input wire SYS_CLK, input wire RST_B, input wire [3:0] AVS_ADDRESS,
   input wire AVS_READ, input wire AVS_WRITE, input wire [31:0] AVS_WRITEDATA,
   input wire [3:0] AVS_BYTEENABLE, input wire AVS_WAITREQUEST,
   // system conditions
   input wire SUBCLOCK_PRESENT, input wire NMI_REQ, input wire IRQ_PENDING_UNMASKED,
   // gating outputs
   input wire IDLE_ACTIVE, input wire CPU_CLK_EN, input wire ROM_CORR_CLK_EN,
   input wire [15:0] PERIPH_CLK_EN, input wire [UART_CH-1:0] UART_RX_CLK_EN,
   input wire PORT_HOLD, input wire EXT_BUS_CLK_EN, input wire EXT_PINS_FLOAT,
   input wire IRQ_LOW_EN, input wire BUS_HOLD_ACKNOWLEDGE
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   // wake sources override entry and end idle
   wire wake = NMI_REQ | IRQ_PENDING_UNMASKED;
   AST_CPU_OFF: assert property (IDLE_ACTIVE |-> !CPU_CLK_EN && !ROM_CORR_CLK_EN)
      else $error("cpu clock running in idle");
   AST_ALL_ON: assert property (!IDLE_ACTIVE |-> PERIPH_CLK_EN == 16'hFFFF)
      else $error("peripheral clock gated outside idle");
   AST_NO_SUB: assert property (IDLE_ACTIVE && !$past(SUBCLOCK_PRESENT) |->
      PERIPH_CLK_EN[2:0] == 3'h0 && PERIPH_CLK_EN[13:12] == 2'h0)
      else $error("subclock unit runs without subclock");
   AST_T6_T7: assert property (IDLE_ACTIVE && |PERIPH_CLK_EN[4:3] |-> PERIPH_CLK_EN[0])
      else $error("timer 6 or 7 runs with timer 0 stopped");
   AST_RX_OFF: assert property (IDLE_ACTIVE |-> UART_RX_CLK_EN == 0)
      else $error("uart receive clock on in idle");
   AST_FIXED: assert property (IDLE_ACTIVE |-> PERIPH_CLK_EN[15:14] == 2'h1)
      else $error("watch or stopped group wrong in idle");
   AST_PORTS: assert property (IDLE_ACTIVE |-> PORT_HOLD && !EXT_BUS_CLK_EN && IRQ_LOW_EN)
      else $error("port, bus or low irq state wrong in idle");
   AST_FLOAT: assert property (!IDLE_ACTIVE |-> !EXT_PINS_FLOAT)
      else $error("pins float outside idle");
   AST_ENTRY: assert property (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h0 &&
      AVS_WRITEDATA[1] && AVS_BYTEENABLE[0] && !wake |=> IDLE_ACTIVE)
      else $error("idle not entered after idle bit write");
   AST_WAKE: assert property (IDLE_ACTIVE && wake |=> !IDLE_ACTIVE)
      else $error("wake did not end idle");
   AST_HOLD: assert property (IDLE_ACTIVE |-> !BUS_HOLD_ACKNOWLEDGE)
      else $error("bus hold granted in idle");
   AST_ONE_WAIT: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("bus answer late");
endmodule // idle_gate_monitor

bind idle_clock_gating idle_gate_monitor #(.UART_CH(UART_CH)) mon (.SYS_CLK(SYS_CLK),
   .RST_B(RST_B), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .SUBCLOCK_PRESENT(SUBCLOCK_PRESENT), .NMI_REQ(NMI_REQ),
   .IRQ_PENDING_UNMASKED(IRQ_PENDING_UNMASKED), .IDLE_ACTIVE(IDLE_ACTIVE),
   .CPU_CLK_EN(CPU_CLK_EN), .ROM_CORR_CLK_EN(ROM_CORR_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
   .UART_RX_CLK_EN(UART_RX_CLK_EN), .PORT_HOLD(PORT_HOLD), .EXT_BUS_CLK_EN(EXT_BUS_CLK_EN),
   .EXT_PINS_FLOAT(EXT_PINS_FLOAT), .IRQ_LOW_EN(IRQ_LOW_EN),
   .BUS_HOLD_ACKNOWLEDGE(BUS_HOLD_ACKNOWLEDGE));

// ---- bench/idle_clock_gating_bench.sv ----
// self-checking bench for the idle gating controller
// assumes the register slave answers every request through waitrequest
module idle_clock_gating_bench;
   timeunit 1ns;
   timeprecision 1ns;
   reg clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, sub = 1'b0, nmi = 1'b0, irq = 1'b0;
   reg hreq = 1'b0;
   reg [3:0] addr = 4'h0;
   reg [31:0] wdata = 32'h0, got;
   reg [31:0] sel_tab [0:3];
   reg [15:0] exp;
   wire [31:0] rdata;
   wire [15:0] pen;
   wire [1:0] rx_en;
   wire wait_req, idle, cpu_en, rom_en, hold, bus_en, flt, low_en, hack;
   integer fails = 0, total_checks = 0, i, n;
   // ----------------------------------------
   // clock and device
   // ----------------------------------------
   always #5 clk = ~clk;
   idle_clock_gating dut (.SYS_CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(addr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wait_req), .SUBCLOCK_PRESENT(sub), .NMI_REQ(nmi),
      .IRQ_PENDING_UNMASKED(irq), .BUS_HOLD_REQUEST(hreq), .BUS_HOLD_GRANT_OK(1'b1),
      .IDLE_ACTIVE(idle), .CPU_CLK_EN(cpu_en), .ROM_CORR_CLK_EN(rom_en), .PERIPH_CLK_EN(pen),
      .UART_RX_CLK_EN(rx_en), .PORT_HOLD(hold), .EXT_BUS_CLK_EN(bus_en),
      .EXT_PINS_FLOAT(flt), .IRQ_LOW_EN(low_en), .BUS_HOLD_ACKNOWLEDGE(hack));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", total_checks, fails);
         if (fails == 0 && total_checks > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] want);
      begin
         total_checks = total_checks + 1;
         if (seen !== want) begin
            fails = fails + 1;
            $display("BAD %0t saw %h want %h", $time, seen, want);
         end
      end
   endtask
   // one transfer; starts after an edge so a release never meets a new request
   task xfer(input w, input [3:0] a, input [31:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr <= w;
         rd <= !w;
         n = 0;
         @(posedge clk);
         while (wait_req !== 1'b0) begin
            n = n + 1;
            if (n > 20) begin
               fails = fails + 1;
               stop_test;
            end
            @(posedge clk);
         end
         got = rdata;
         wr <= 1'b0;
         rd <= 1'b0;
      end
   endtask
   // expected keep-running flags, worked out independently of the design
   function [15:0] run_flags(input s, input [31:0] c);
      reg t0, t4, t5;
      begin
         t0 = s & c[0] & c[1];
         t4 = s & c[2];
         t5 = s & c[3];
         run_flags = {1'b0, 1'b1, s & c[17], s & (c[15] & t4 | c[16] & t5), c[14:8],
            c[5] & t0, c[4] & t0, t5, t4, t0};
      end
   endfunction
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      sel_tab[0] = 32'h0003FFFF;
      sel_tab[1] = 32'h00000000;
      sel_tab[2] = 32'h0000003D;
      sel_tab[3] = 32'h0001A0AA;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      hreq <= 1'b1;
      xfer(0, 4'h0, 32'h0);
      chk(got, 32'h0);
      xfer(0, 4'h2, 32'h0);
      chk(got, 32'h0);
      chk({31'h0, hack}, 32'h1);
      // every selection with and without subclock, both wake sources
      for (i = 0; i < 8; i = i + 1) begin
         sub <= i[2];
         xfer(1, 4'h4, sel_tab[i % 4]);
         xfer(0, 4'h4, 32'h0);
         chk(got, sel_tab[i % 4]);
         xfer(1, 4'h0, i[0] ? 32'h12 : 32'h2);
         @(posedge clk);
         exp = run_flags(i[2], sel_tab[i % 4]);
         chk({22'h0, idle, cpu_en, rom_en, rx_en, hold, bus_en, flt, low_en, hack},
            {22'h0, 5'h10, 1'b1, 1'b0, i[0], 2'h2});
         chk({16'h0, pen}, {16'h0, exp});
         xfer(0, 4'h8, 32'h0);
         chk(got, {15'h0, 1'b1, exp});
         if (i[1]) nmi <= 1'b1;
         else irq <= 1'b1;
         @(posedge clk);
         nmi <= 1'b0;
         irq <= 1'b0;
         @(posedge clk);
         chk({14'h0, idle, cpu_en, pen}, {14'h0, 2'h1, 16'hFFFF});
         xfer(0, 4'h0, 32'h0);
         chk(got, i[0] ? 32'h10 : 32'h0);
      end
      // reset in mid-run also ends idle and clears the request bit
      xfer(1, 4'h0, 32'h2);
      @(posedge clk);
      chk({31'h0, idle}, 32'h1);
      rst_b <= 1'b0;
      @(posedge clk);
      chk({30'h0, idle, cpu_en}, 32'h1);
      rst_b <= 1'b1;
      xfer(0, 4'h0, 32'h0);
      chk(got, 32'h0);
      stop_test;
   end
endmodule // idle_clock_gating_bench
